// ===== logic/acp_pkg.sv
// package: constants and types of the adc serial command port
`default_nettype none
package acp_pkg;
    localparam int unsigned acp_clk_mhz = 100;
    localparam int unsigned acp_resync_ones = 32;
    localparam int unsigned acp_low_power_mhz = 4;
    localparam logic [5:0] acp_addr_command = 6'h00;
    localparam logic [5:0] acp_addr_io_port = 6'h01;
    localparam logic [5:0] acp_addr_revision = 6'h02;
    localparam logic [5:0] acp_addr_status = 6'h04;
    localparam logic [5:0] acp_addr_checksum = 6'h05;
    localparam logic [5:0] acp_addr_data_base = 6'h08;
    localparam logic [5:0] acp_addr_chan_status_base = 6'h20;
    localparam logic [5:0] acp_addr_setup_base = 6'h28;
    localparam logic [5:0] acp_addr_mode_base = 6'h38;
    localparam logic [5:0] acp_page_mask = 6'h38;
    localparam logic [7:0] acp_io_reset = 8'h30;
    localparam logic [7:0] acp_io_wmask = 8'hfd;
    localparam logic [7:0] acp_setup_reset = 8'h00;
    localparam int unsigned acp_cmd_rw_bit = 6;
    localparam int unsigned acp_io_pin_a_bit = 7;
    localparam int unsigned acp_io_pin_b_bit = 6;
    localparam int unsigned acp_io_dir_a_bit = 5;
    localparam int unsigned acp_io_dir_b_bit = 4;
    localparam int unsigned acp_io_policy_bit = 3;
    localparam int unsigned acp_io_lowpwr_bit = 2;
    localparam int unsigned acp_io_sync_bit = 0;
    localparam int unsigned acp_setup_enable_bit = 3;
    localparam int unsigned acp_setup_cfg_hi_bit = 6;
    localparam int unsigned acp_setup_cfg_lo_bit = 5;
    localparam logic [4:0] acp_width_8 = 5'h08;
    localparam logic [4:0] acp_width_16 = 5'h10;
    localparam logic [4:0] acp_width_24 = 5'h18;
    localparam logic [5:0] acp_ones_max = 6'h20;
    localparam logic [4:0] acp_pins_idle = 5'h18;
    typedef enum logic [2:0] {
        acp_st_cmd = 3'b001,
        acp_st_write = 3'b010,
        acp_st_read = 3'b100
    } acp_state_t;
endpackage : acp_pkg
`default_nettype wire

// ===== logic/acp_regs_if.sv
// interface: register access between serial engine and setup store
`default_nettype none
interface acp_regs_if;
    logic wr_en;
    logic clear;
    logic [2:0] addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    modport engine (output wr_en, output clear, output addr, output wr_data, input rd_data);
    modport store (input wr_en, input clear, input addr, input wr_data, output rd_data);
endinterface : acp_regs_if
`default_nettype wire

// ===== logic/acp_setup_mem.sv
// module: per-channel setup memory with registered read data
`default_nettype none
module acp_setup_mem
    import acp_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // access port
    acp_regs_if.store regs
);
    logic [7:0] mem [8];
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 8; i++)
                mem[i] <= acp_setup_reset;
        end
        else if (regs.clear)
        begin
            for (int i = 0; i < 8; i++)
                mem[i] <= acp_setup_reset;
        end
        else if (regs.wr_en)
            mem[regs.addr] <= regs.wr_data;
    end
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            regs.rd_data <= acp_setup_reset;
        else
            regs.rd_data <= mem[regs.addr];
    end
endmodule : acp_setup_mem
`default_nettype wire

// ===== logic/acp_top.sv
// module: serial command port, io port register and interface resync
// Functional notes
// - every transaction starts with a command byte
// - return to command wait after transfer
// - 32 ones with select low resets engine, io port, setup and mode data; mode channel is kept
// - command bit 6 selects read or write
// - bits 5..0 address, low three pick channel
// - mode write channel from address low bits
// - channel input pair from config bits
// - port bits drive or mirror the pins
// - direction bits: one input, zero output, except pin b stays input while bit 0 sync is set
// - ready policy: any unread (enables ignored) or all enabled
// - bit 2 selects reduced power
// - bit 0 enables sync pin function
// - io port reset value with pin levels
// - data phase width follows register
`default_nettype none
module acp_top
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // serial link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    // port pins (oe low drives)
    input wire logic port_pin_a_in,
    output logic port_pin_a_out,
    output logic port_pin_a_oe_n,
    input wire logic port_pin_b_in,
    output logic port_pin_b_out,
    output logic port_pin_b_oe_n,
    // converter side
    input wire logic [7:0] unread,
    input wire logic [7:0] status_in,
    output logic ready_n,
    output logic low_power_select,
    output logic sync_enable,
    output logic [2:0] mode_channel,
    output logic mode_write,
    output logic [7:0] mode_data,
    output logic interface_reset,
    output logic [7:0] channel_enable,
    output logic [15:0] input_config
);
    import acp_pkg::*;

    function automatic logic [4:0] reg_width(input logic [5:0] a);
        if ((a & acp_page_mask) == acp_addr_data_base || a == acp_addr_checksum)
            reg_width = acp_width_16;
        else if (a == acp_addr_command || a == acp_addr_io_port || a == acp_addr_revision || a == acp_addr_status)
            reg_width = acp_width_8;
        else if (a >= acp_addr_chan_status_base) // status, setup, conversion time and mode pages are bytes
            reg_width = acp_width_8;
        else
            reg_width = acp_width_24;
    endfunction : reg_width

    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // three-stage samplers, change taken when stages two and three agree
    // bit order: select, clock, data, pin a, pin b; idle levels avoid a false edge after reset
    logic [4:0] st1, st2, st3, seen;
    logic cs_q, clk_q, din_q, pa_q, pb_q;
    logic clk_d;
    logic rise, fall;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st1 <= acp_pins_idle;
            st2 <= acp_pins_idle;
            st3 <= acp_pins_idle;
            seen <= acp_pins_idle;
            clk_d <= 1'b1;
        end
        else
        begin
            st1 <= {cs_n, sclk, din, port_pin_a_in, port_pin_b_in};
            st2 <= st1;
            st3 <= st2;
            seen <= (seen & (st2 ^ st3)) | (st3 & ~(st2 ^ st3));
            clk_d <= clk_q;
        end
    end
    assign {cs_q, clk_q, din_q, pa_q, pb_q} = seen;
    assign rise = clk_q && !clk_d && !cs_q;
    assign fall = !clk_q && clk_d && !cs_q;

    // resync: count rising edges with data in high
    logic [5:0] ones;
    logic soft_rst;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            ones <= 6'h0;
        else if (soft_rst || cs_q)
            ones <= 6'h0;
        else if (rise)
            ones <= din_q ? ones + 6'h1 : 6'h0;
    end
    assign soft_rst = (ones == acp_ones_max);

    // serial engine
    acp_state_t state;
    logic [23:0] shreg;
    logic [7:0] cmd_word;
    logic [4:0] cnt;
    logic [4:0] width;
    logic [5:0] addr;
    logic [7:0] rd_word;
    logic [7:0] io_port_control;
    logic [7:0] io_view;
    logic done_byte, done_data;
    acp_regs_if regs ();

    assign done_byte = rise && (cnt == acp_width_8 - 5'h1);
    assign done_data = rise && (cnt == width - 5'h1);
    // the eighth bit is still on the data line when the byte completes
    assign cmd_word = {shreg[6:0], din_q};
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= acp_st_cmd;
            cnt <= 5'h0;
            shreg <= 24'h0;
            addr <= 6'h0;
            width <= acp_width_8;
        end
        else if (soft_rst)
        begin
            state <= acp_st_cmd;
            cnt <= 5'h0;
            shreg <= 24'h0;
        end
        else if (rise)
        begin
            shreg <= {shreg[22:0], din_q};
            case (state)
                acp_st_cmd:
                begin
                    cnt <= done_byte ? 5'h0 : cnt + 5'h1;
                    if (done_byte)
                    begin
                        addr <= cmd_word[5:0];
                        width <= reg_width(cmd_word[5:0]);
                        state <= cmd_word[acp_cmd_rw_bit] ? acp_st_read : acp_st_write;
                    end
                end
                acp_st_write, acp_st_read:
                begin
                    cnt <= done_data ? 5'h0 : cnt + 5'h1;
                    if (done_data)
                        state <= acp_st_cmd;
                end
                default:
                    state <= acp_st_cmd;
            endcase
        end
        else if (state == acp_st_read && cnt == 5'h0 && !fall && clk_q)
            shreg <= {rd_word, 16'h0};
    end

    // read word: first data bit goes out right after the command byte
    assign io_view = {io_port_control[acp_io_dir_a_bit] ? pa_q : io_port_control[acp_io_pin_a_bit],
        io_port_control[acp_io_dir_b_bit] ? pb_q : io_port_control[acp_io_pin_b_bit],
        io_port_control[5:0]};
    always_comb
    begin
        if (addr == acp_addr_io_port)
            rd_word = io_view;
        else if (addr == acp_addr_status)
            rd_word = status_in;
        else if ((addr & acp_page_mask) == acp_addr_setup_base)
            rd_word = regs.rd_data;
        else
            rd_word = mode_data;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            dout <= 1'b0;
        else if (state != acp_st_read || cs_q)
            dout <= 1'b0;
        else if (fall || cnt == 5'h0)
            dout <= (cnt == 5'h0) ? rd_word[7] : shreg[23];
    end

    logic wr_done;
    assign wr_done = state == acp_st_write && done_data && !soft_rst;
    assign regs.wr_en = wr_done && ((addr & acp_page_mask) == acp_addr_setup_base);
    assign regs.addr = addr[2:0];
    assign regs.clear = soft_rst;
    assign regs.wr_data = {shreg[6:0], din_q};
    acp_setup_mem u_setup (
        .mclk (mclk),
        .rst_n (rst_n),
        .regs (regs)
    );

    // io port register; pins come up as inputs, so io_view shows their live levels
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            io_port_control <= acp_io_reset;
        else if (soft_rst)
            io_port_control <= acp_io_reset;
        else if (wr_done && addr == acp_addr_io_port)
            io_port_control <= {shreg[6:0], din_q} & acp_io_wmask;
    end

    // shadow of the setup bits for enable and input config
    logic [7:0] en_shadow;
    logic [15:0] cfg_shadow;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            {en_shadow, cfg_shadow} <= 24'h0;
        else if (soft_rst)
            {en_shadow, cfg_shadow} <= 24'h0;
        else if (regs.wr_en)
        begin
            en_shadow[addr[2:0]] <= regs.wr_data[acp_setup_enable_bit];
            cfg_shadow[{addr[2:0], 1'b0} +: 2] <= {regs.wr_data[acp_setup_cfg_hi_bit],
                regs.wr_data[acp_setup_cfg_lo_bit]};
        end
    end

    // outputs, all registered
    logic [7:0] pend_en;
    assign pend_en = unread & en_shadow;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready_n <= 1'b1;
            low_power_select <= 1'b0;
            sync_enable <= 1'b0;
            port_pin_a_out <= 1'b0;
            port_pin_a_oe_n <= 1'b1;
            port_pin_b_out <= 1'b0;
            port_pin_b_oe_n <= 1'b1;
            mode_channel <= 3'h0;
            mode_write <= 1'b0;
            mode_data <= 8'h0;
            interface_reset <= 1'b0;
            channel_enable <= 8'h0;
            input_config <= 16'h0;
        end
        else
        begin
            if (io_port_control[acp_io_policy_bit])
                ready_n <= !((pend_en == en_shadow) && (en_shadow != 8'h0));
            else
                ready_n <= !(|unread);
            low_power_select <= io_port_control[acp_io_lowpwr_bit];
            sync_enable <= io_port_control[acp_io_sync_bit];
            port_pin_a_out <= io_port_control[acp_io_pin_a_bit];
            port_pin_a_oe_n <= io_port_control[acp_io_dir_a_bit];
            port_pin_b_out <= io_port_control[acp_io_pin_b_bit];
            port_pin_b_oe_n <= io_port_control[acp_io_dir_b_bit] || io_port_control[acp_io_sync_bit];
            mode_write <= wr_done && ((addr & acp_page_mask) == acp_addr_mode_base);
            if (wr_done && ((addr & acp_page_mask) == acp_addr_mode_base))
            begin
                mode_channel <= addr[2:0];
                mode_data <= {shreg[6:0], din_q};
            end
            else if (soft_rst)
                mode_data <= 8'h0;
            interface_reset <= soft_rst;
            channel_enable <= en_shadow;
            input_config <= cfg_shadow;
        end
    end
endmodule : acp_top
`default_nettype wire

// ===== tb/acp_chk.sv
// checker: port-level properties of the serial command port
`default_nettype none
module acp_chk
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // observed ports
    input wire logic cs_n,
    input wire logic port_pin_a_oe_n,
    input wire logic port_pin_b_oe_n,
    input wire logic [7:0] unread,
    input wire logic ready_n,
    input wire logic low_power_select,
    input wire logic sync_enable,
    input wire logic mode_write,
    input wire logic interface_reset
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    chk_sync_b_input: assert property (sync_enable |-> port_pin_b_oe_n)
        else $error("pin b driven with sync on");
    // ready is registered, so it answers the flags of the cycle before
    chk_ready_cause: assert property ($past(unread) == 8'h00 |-> ready_n)
        else $error("ready without unread data");
    chk_mode_pulse: assert property (mode_write |=> !mode_write)
        else $error("mode write longer than one cycle");
    chk_ireset_pulse: assert property (interface_reset |=> !interface_reset)
        else $error("resync pulse too long");
    chk_ireset_clear: assert property (interface_reset |-> ##[0:4] (!low_power_select && !sync_enable
        && port_pin_a_oe_n && port_pin_b_oe_n))
        else $error("io port not cleared by resync");
    chk_sync_serial: assert property ($changed(sync_enable) |-> !$past(cs_n, 4))
        else $error("sync enable moved outside a frame");
    chk_dir_serial: assert property ($changed(port_pin_a_oe_n) |-> !$past(cs_n, 4))
        else $error("pin a direction moved outside a frame");
    chk_mode_frame: assert property (mode_write |-> !$past(cs_n, 4))
        else $error("mode write outside a frame");

    cover property (mode_write);
    cover property (interface_reset);
    cover property ($fell(ready_n));
endmodule : acp_chk
`default_nettype wire

// ===== tb/acp_host.sv
// host model: serial master driving select, clock and data
`default_nettype none
module acp_host
(
    // clock
    input wire logic mclk,
    // serial link
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end

    // data moves on the fall, device samples on the rise
    task automatic bit_io(input logic b, output logic q);
        sclk = 1'b0;
        din = b;
        repeat (4) @(negedge mclk);
        sclk = 1'b1;
        repeat (4) @(negedge mclk);
        q = dout;
    endtask : bit_io

    // select idles long enough to pass the device's pin filter
    task automatic open_frame;
        repeat (4) @(negedge mclk);
        cs_n = 1'b0;
        repeat (4) @(negedge mclk);
    endtask : open_frame

    // idle data line must not look held at its last level
    task automatic close_frame;
        repeat (8) @(negedge mclk);
        cs_n = 1'b1;
        din = ~din;
    endtask : close_frame

    task automatic frame(input logic [7:0] cmd, input logic [23:0] wd, input int n, output logic [23:0] rd);
        logic q;
        rd = 24'h0;
        open_frame();
        for (int i = 7; i >= 0; i--) bit_io(cmd[i], q);
        for (int i = n - 1; i >= 0; i--)
        begin
            bit_io(wd[i], q);
            rd[i] = q;
        end
        close_frame();
    endtask : frame

    task automatic ones;
        logic q;
        open_frame();
        repeat (32) bit_io(1'b1, q);
        close_frame();
    endtask : ones
endmodule : acp_host
`default_nettype wire

// ===== tb/testbench.sv
// testbench: reset, io port, ready policy, mode and resync scenarios
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic ext_a = 1'b1;
    logic ext_b = 1'b0;
    logic [7:0] unread = 8'h00;
    logic [7:0] status_in = 8'ha5;
    logic [23:0] rd;
    int n_mismatch = 0;
    int tests_run = 0;
    int n_mode = 0;
    int n_rst = 0;
    wire logic cs_n, sclk, din, dout, pa_in, pb_in, pa_out, pb_out, pa_oe_n, pb_oe_n;
    wire logic ready_n, low_power_select, sync_enable, mode_write, interface_reset;
    wire logic [2:0] mode_channel;
    wire logic [7:0] mode_data, channel_enable;
    wire logic [15:0] input_config;

    // pin level resolves from both drivers
    assign pa_in = pa_oe_n ? ext_a : pa_out;
    assign pb_in = pb_oe_n ? ext_b : pb_out;

    initial forever #5 mclk = ~mclk;

    acp_top dut_u (.mclk, .resetn, .cs_n, .sclk, .din, .dout,
        .port_pin_a_in(pa_in), .port_pin_a_out(pa_out), .port_pin_a_oe_n(pa_oe_n),
        .port_pin_b_in(pb_in), .port_pin_b_out(pb_out), .port_pin_b_oe_n(pb_oe_n),
        .unread, .status_in, .ready_n, .low_power_select, .sync_enable, .mode_channel,
        .mode_write, .mode_data, .interface_reset, .channel_enable, .input_config);
    acp_host host_u (.mclk, .cs_n, .sclk, .din, .dout);

    always @(negedge mclk)
    begin
        if (mode_write === 1'b1) n_mode++;
        if (interface_reset === 1'b1) n_rst++;
    end

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    task automatic t_reset;
        host_u.frame(8'h41, 24'h0, 8, rd);
        check("io reset", 24'hb0, rd);
        check("pin enables", 24'h3, 24'({pa_oe_n, pb_oe_n}));
        check("power sync", 24'h0, 24'({low_power_select, sync_enable}));
        $display("test reset done");
    endtask : t_reset

    task automatic t_io;
        host_u.frame(8'h01, 24'h4d, 8, rd);
        check("io 4d", 24'h07, 24'({pa_oe_n, pa_out, pb_oe_n, low_power_select, sync_enable}));
        host_u.frame(8'h01, 24'h88, 8, rd);
        check("io 88", 24'h10, 24'({pa_oe_n, pa_out, pb_oe_n, pb_out, low_power_select, sync_enable}));
        host_u.frame(8'h41, 24'h0, 8, rd);
        check("io drive read", 24'h88, rd);
        ext_a = 1'b0;
        ext_b = 1'b1;
        host_u.frame(8'h01, 24'h30, 8, rd);
        host_u.frame(8'h41, 24'h0, 8, rd);
        check("io pin read", 24'h70, rd);
        $display("test io done");
    endtask : t_io

    task automatic t_ready;
        check("ready idle", 24'h1, 24'(ready_n));
        unread = 8'h04;
        repeat (4) @(negedge mclk);
        check("ready any", 24'h0, 24'(ready_n));
        host_u.frame(8'h2b, 24'h68, 8, rd);
        check("setup ch3", 24'h0800c0, {channel_enable, input_config});
        host_u.frame(8'h6b, 24'h0, 8, rd);
        check("setup ch3 read", 24'h68, rd);
        host_u.frame(8'h01, 24'h38, 8, rd);
        check("ready all", 24'h1, 24'(ready_n));
        unread = 8'h08;
        repeat (4) @(negedge mclk);
        check("ready all met", 24'h0, 24'(ready_n));
        unread = 8'h00;
        $display("test ready done");
    endtask : t_ready

    task automatic t_mode;
        host_u.frame(8'h3d, 24'h20, 8, rd);
        check("mode pulses", 24'h1, 24'(n_mode));
        check("mode channel", 24'h520, 24'({mode_channel, mode_data}));
        host_u.frame(8'h78, 24'h0, 8, rd);
        check("mode read", 24'h20, rd);
        host_u.frame(8'h48, 24'h0, 16, rd);
        host_u.frame(8'h44, 24'h0, 8, rd);
        check("status read", 24'ha5, rd);
        $display("test mode done");
    endtask : t_mode

    task automatic t_resync;
        host_u.frame(8'h01, 24'h0c, 8, rd);
        host_u.ones();
        check("resync pulse", 24'h1, 24'(n_rst));
        check("power cleared", 24'h0, 24'(low_power_select));
        check("setup cleared", 24'h0, {channel_enable, input_config});
        host_u.frame(8'h6b, 24'h0, 8, rd);
        check("setup read after resync", 24'h0, rd);
        host_u.frame(8'h41, 24'h0, 8, rd);
        check("io after resync", 24'({ext_a, ext_b, 6'h30}), rd);
        $display("test resync done");
    endtask : t_resync

    initial
    begin
        repeat (6) @(negedge mclk);
        resetn = 1'b1;
        repeat (12) @(negedge mclk);
        t_reset();
        t_io();
        t_ready();
        t_mode();
        t_resync();
        end_of_test();
    end

    // hang guard
    initial
    begin
        repeat (100000) @(posedge mclk);
        n_mismatch++;
        end_of_test();
    end
endmodule : testbench

bind acp_top acp_chk chk_u (.mclk, .resetn, .cs_n, .port_pin_a_oe_n, .port_pin_b_oe_n, .unread,
    .ready_n, .low_power_select, .sync_enable, .mode_write, .interface_reset);
`default_nettype wire
